/* File: nie_regs.svh */
// Purpose: Opcodes, field positions and pin timing of the nibble expander link
// Assumes: Times are in nanoseconds; the clock period is given in ns as well
// Notes:   Cycle counts are derived from these in the host module
`ifndef NIE_REGS_SVH
`define NIE_REGS_SVH

`define NIE_OP_READ      2'h0
`define NIE_OP_WRITE     2'h1
`define NIE_OP_OR        2'h2
`define NIE_OP_AND       2'h3

`define NIE_NPORTS       4
`define NIE_NIB_W        4

`define NIE_CLK_NS       25
`define NIE_T_INST_SU_NS 100
`define NIE_T_INST_H_NS  60
`define NIE_T_DATA_SU_NS 200
`define NIE_T_DATA_H_NS  20
`define NIE_T_PW_NS      700
`define NIE_T_CS_SU_NS   50
`define NIE_T_CS_H_NS    50
`define NIE_T_ACC_NS     650
`define NIE_T_FLOAT_NS   150
`define NIE_T_SWITCH_NS  800

`define NIE_SYNC_STAGES  2
`define NIE_CNT_W        6

`endif

/* File: nie_pkg.sv */
// Purpose: Types shared by the nibble expander host
// Assumes: nie_regs.svh holds the numeric constants
// Notes:   Command travels as one packed struct
`include "nie_regs.svh"

package nie_pkg;

  typedef struct packed {
    logic [1:0]                op;
    logic [1:0]                port;
    logic [`NIE_NIB_W-1:0]     data;
  } nie_cmd_s;

  typedef enum logic [2:0] {
    NIE_IDLE,
    NIE_SETUP,
    NIE_INSTHOLD,
    NIE_RDWAIT,
    NIE_WRDATA,
    NIE_POST,
    NIE_GAP
  } nie_state_e;

endpackage : nie_pkg

/* File: nie_host.sv */
// Purpose: Host controller driving a four-port nibble I/O expander over its pins
// Assumes: Expander keeps its own rules; nibble pin input is asynchronous
// Notes:   One transfer at a time; reads of an output-mode port get a dummy read
// What this block does
// - Upper bits opcode, lower bits port select.
// - Host drives opcode and port with chip select, before strobe fall.
// - Host samples during low, then raises strobe.
// - Host issues dummy read after output mode.
`timescale 1ns/1ps
`include "nie_regs.svh"

module nie_host (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  reqValid,
  input  wire nie_pkg::nie_cmd_s     reqCmd,
  output logic                       busy,
  output logic                       done,
  output logic [`NIE_NIB_W-1:0]      rdData,
  output logic [`NIE_NPORTS-1:0]     portOutMode,
  output logic                       csN,
  output logic                       strobe,
  input  wire logic [`NIE_NIB_W-1:0] nibIn,
  output logic [`NIE_NIB_W-1:0]      nibOut,
  output logic                       nibOe
);
  import nie_pkg::*;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + `NIE_CLK_NS - 1) / `NIE_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int INST_SU = cyc_up(`NIE_T_INST_SU_NS);
  localparam int CS_SU   = cyc_up(`NIE_T_CS_SU_NS);
  localparam int INST_H  = cyc_up(`NIE_T_INST_H_NS);
  localparam int DATA_SU = cyc_up(`NIE_T_DATA_SU_NS);
  localparam int DATA_H  = cyc_up(`NIE_T_DATA_H_NS);
  localparam int CS_H    = cyc_up(`NIE_T_CS_H_NS);
  localparam int PW      = cyc_up(`NIE_T_PW_NS);
  localparam int ACC     = cyc_up(`NIE_T_ACC_NS) + `NIE_SYNC_STAGES;
  localparam int FLOAT   = cyc_up(`NIE_T_FLOAT_NS);
  localparam int SWITCH  = cyc_up(`NIE_T_SWITCH_NS);
  localparam int SETUP_C = (INST_SU > CS_SU) ? INST_SU : CS_SU;
  localparam int RDLOW0  = PW - INST_H;
  localparam int RDLOW   = (RDLOW0 > ACC) ? RDLOW0 : ACC;
  localparam int WRLOW   = (RDLOW0 > DATA_SU) ? RDLOW0 : DATA_SU;
  localparam int WRPOST  = (DATA_H > CS_H) ? DATA_H : CS_H;
  localparam int RDPOST  = (FLOAT > CS_H) ? FLOAT : CS_H;

  nie_state_e               state;
  nie_cmd_s                 cmd;
  logic [`NIE_CNT_W-1:0]    cnt;
  logic                     dummyPend;
  logic [`NIE_NIB_W-1:0]    nibSync1;
  logic [`NIE_NIB_W-1:0]    nibSync2;
  logic [`NIE_NIB_W-1:0]    next_nib;
  logic                     isRead;

  assign isRead = (cmd.op == `NIE_OP_READ);

  // Opcode in the upper pair, port select in the lower pair
  always_comb begin
    next_nib = {cmd.op, cmd.port};
  end

  // Two-stage synchroniser on the nibble pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nibSync1 <= 4'h0;
      nibSync2 <= 4'h0;
    end else begin
      nibSync1 <= nibIn;
      nibSync2 <= nibSync1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= NIE_IDLE;
      cmd       <= '0;
      cnt       <= '0;
      dummyPend <= 1'b0;
      csN       <= 1'b1;
      strobe    <= 1'b1;
      nibOut    <= 4'h0;
      nibOe     <= 1'b0;
      busy      <= 1'b0;
    end else begin
      unique case (state)
        NIE_IDLE: begin
          if (reqValid) begin
            cmd       <= reqCmd;
            busy      <= 1'b1;
            dummyPend <= (reqCmd.op == `NIE_OP_READ) && portOutMode[reqCmd.port];
            csN       <= 1'b0;
            nibOut    <= {reqCmd.op, reqCmd.port};
            nibOe     <= 1'b1;
            cnt       <= `NIE_CNT_W'(SETUP_C - 1);
            state     <= NIE_SETUP;
          end
        end
        NIE_SETUP: begin
          if (cnt == '0) begin
            strobe <= 1'b0;
            cnt    <= `NIE_CNT_W'(INST_H - 1);
            state  <= NIE_INSTHOLD;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        NIE_INSTHOLD: begin
          if (cnt == '0) begin
            if (isRead) begin
              nibOe <= 1'b0;
              cnt   <= `NIE_CNT_W'(RDLOW - 1);
              state <= NIE_RDWAIT;
            end else begin
              nibOut <= cmd.data;
              cnt    <= `NIE_CNT_W'(WRLOW - 1);
              state  <= NIE_WRDATA;
            end
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        NIE_RDWAIT: begin
          if (cnt == '0) begin
            strobe <= 1'b1;
            cnt    <= `NIE_CNT_W'(RDPOST - 1);
            state  <= NIE_POST;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        NIE_WRDATA: begin
          if (cnt == '0) begin
            strobe <= 1'b1;
            cnt    <= `NIE_CNT_W'(WRPOST - 1);
            state  <= NIE_POST;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        NIE_POST: begin
          if (cnt == '0) begin
            csN   <= 1'b1;
            nibOe <= 1'b0;
            cnt   <= `NIE_CNT_W'(dummyPend ? SWITCH - 1 : CS_SU - 1);
            state <= NIE_GAP;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        NIE_GAP: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (dummyPend) begin
            // Repeat the read once the port has had the switch time (SWITCH cycles) to leave output mode
            dummyPend <= 1'b0;
            csN       <= 1'b0;
            nibOut    <= next_nib;
            nibOe     <= 1'b1;
            cnt       <= `NIE_CNT_W'(SETUP_C - 1);
            state     <= NIE_SETUP;
          end else begin
            busy  <= 1'b0;
            state <= NIE_IDLE;
          end
        end
      endcase
    end
  end

  // Completion pulse and read sample just before the rising strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done   <= 1'b0;
      rdData <= 4'h0;
    end else begin
      done <= (state == NIE_GAP) && (cnt == '0) && !dummyPend;
      if (state == NIE_RDWAIT && cnt == '0) begin
        rdData <= nibSync2;
      end
    end
  end

  // Mirror of the expander port modes, all inputs after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      portOutMode <= '0;
    end else if (state == NIE_POST && cnt == '0) begin
      portOutMode[cmd.port] <= !isRead;
    end
  end

  // Helper counters watched only by the checks below
  logic [`NIE_CNT_W-1:0] lowCnt;
  logic [1:0]            fallCnt;
  logic                  hadOut;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt  <= '0;
      fallCnt <= '0;
      hadOut  <= 1'b0;
    end else begin
      lowCnt <= strobe ? '0 : lowCnt + 1'b1;
      if (state == NIE_IDLE && reqValid) begin
        fallCnt <= '0;
        hadOut  <= portOutMode[reqCmd.port];
      end else if (state == NIE_SETUP && cnt == '0) begin
        fallCnt <= fallCnt + 1'b1;
      end
    end
  end

  AST_STROBE_UNDER_CS: assert property (@(posedge mclk) disable iff (!rst_n)
    !strobe |-> !csN)
    else $error("strobe low while chip select high");

  AST_CMD_AT_FALL: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(strobe) |-> nibOe && nibOut == {cmd.op, cmd.port} && $past(nibOe, 4))
    else $error("command nibble not driven and set up at strobe fall");

  AST_OPCODE_LAYOUT: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(strobe) |-> nibOut[3:2] == cmd.op && nibOut[1:0] == cmd.port)
    else $error("opcode or port bits misplaced");

  AST_READ_RELEASED: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(strobe) && isRead |-> ##3 !nibOe [*8])
    else $error("host drives nibble during read");

  AST_LOW_WIDTH: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(strobe) |-> $past(lowCnt) >= PW - 1)
    else $error("strobe low pulse too short");

  AST_DUMMY_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    done && isRead && hadOut |-> fallCnt == 2'h2)
    else $error("no dummy read before reading an output port");

  AST_DONE_BOUND: assert property (@(posedge mclk) disable iff (!rst_n)
    state == NIE_IDLE && reqValid |-> ##[36:120] done)
    else $error("transfer did not complete in time");

endmodule : nie_host

/* File: nie_exp_model.sv */
// Purpose: Behavioural four-port nibble expander facing the host
// Assumes: No clock inside the device; host times its pins
// Notes:   Reads garble while a port leaves output mode
`timescale 1ns/1ps
module nie_exp_model (
  input  wire logic        csN,
  input  wire logic        strobe,
  input  wire logic [3:0]  nib,
  input  wire logic [15:0] extIn,
  output logic [3:0]       devNib,
  output logic [15:0]      pins,
  output logic [3:0]       mode,
  output int               tErr
);
  logic [15:0] latchQ;
  logic [3:0]  instr;
  logic        junk;
  logic        sw;
  logic        rdOn;
  realtime     tNib;
  // Far in the past, so the strobe rising out of reset is not timed as a pulse
  realtime     tFall = -1.0e6;
  wire effStb = strobe | csN;
  initial begin
    mode = 4'h0;
    latchQ = 16'h0;
    instr = 4'h0;
    junk = 1'b0;
    sw = 1'b0;
    tErr = 0;
    tNib = 0;
  end
  always #17 junk = ~junk;
  always @(nib) tNib = $realtime;
  always @(negedge effStb) begin
    tFall = $realtime;
    if ($realtime - tNib < 100) tErr++;
    instr = nib;
    if (nib[3:2] == 2'h0 && mode[nib[1:0]]) begin
      mode[nib[1:0]] = 1'b0;
      sw = 1'b1;
      sw <= #800 1'b0;
    end
  end
  always @(posedge effStb) begin
    if ($realtime - tFall < 700) tErr++;
    if (instr[3:2] != 2'h0) begin
      if ($realtime - tNib < 200) tErr++;
      case (instr[3:2])
        2'h1: latchQ[instr[1:0]*4 +: 4] = nib;
        2'h2: latchQ[instr[1:0]*4 +: 4] |= nib;
        default: latchQ[instr[1:0]*4 +: 4] &= nib;
      endcase
      mode[instr[1:0]] = 1'b1;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins[i*4 +: 4] = mode[i] ? latchQ[i*4 +: 4] : extIn[i*4 +: 4];
    end
  end
  assign rdOn = !effStb && instr[3:2] == 2'h0;
  // Released lines show a moving pattern, never the last value
  assign devNib = !rdOn ? {4{junk}} ^ 4'h5 :
                  {4{sw}} ^ pins[instr[1:0]*4 +: 4];
endmodule : nie_exp_model

/* File: nie_host_tb.sv */
// Purpose: Self-checking bench for the nibble expander host
// Assumes: Expander model sits on the far side of the pins
// Notes:   Row = {cmd, expected nibble, expected modes}
`timescale 1ns/1ps
module nie_host_tb;
  import nie_pkg::*;
  logic        mclk, rst_n, reqValid, busy, done, csN, strobe, nibOe;
  nie_cmd_s    reqCmd;
  logic [3:0]  rdData, portOutMode, nibOut, devNib, mode;
  logic [15:0] pins;
  int          tErr, err_total, n_tests;
  wire logic [3:0] nibWire = nibOe ? nibOut : devNib;
  logic [15:0] rows [11] = '{16'h4AA1, 16'h85F1, 16'hC661, 16'h00C0, 16'h5332, 16'h20A2,
                             16'h7CCA, 16'hB1DA, 16'h1058, 16'hF758, 16'h3090};
  nie_host i_nie_host (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqCmd(reqCmd),
    .busy(busy), .done(done), .rdData(rdData), .portOutMode(portOutMode), .csN(csN),
    .strobe(strobe), .nibIn(nibWire), .nibOut(nibOut), .nibOe(nibOe));
  nie_exp_model i_nie_exp_model (.csN(csN), .strobe(strobe), .nib(nibWire),
    .extIn(16'h9A5C), .devNib(devNib), .pins(pins), .mode(mode), .tErr(tErr));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // Hold keeps a changed request up while busy; it must be ignored
  task automatic run(input logic [7:0] c, input logic hold);
    @(posedge mclk);
    #2;
    reqValid = 1'b1;
    reqCmd = c;
    @(posedge mclk);
    #2;
    reqValid = hold;
    reqCmd = c ^ 8'h01;
    for (int k = 0; k < 400 && done !== 1'b1; k++) begin
      @(posedge mclk);
      #2;
    end
    reqValid = 1'b0;
    check(done, 1'b1, "done");
  endtask : run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqCmd = 8'h00;
    err_total = 0;
    n_tests = 0;
    repeat (4) @(posedge mclk);
    #2;
    check({csN, strobe, nibOe, busy, portOutMode}, 8'hC0, "reset pins");
    check(mode, 4'h0, "power-up modes");
    rst_n = 1'b1;
    foreach (rows[r]) begin
      run(rows[r][15:8], 1'b0);
      if (rows[r][15:14] == 2'h0)
        check(rdData, rows[r][7:4], "read data");
      else
        check(pins[rows[r][13:12]*4 +: 4], rows[r][7:4], "pins");
      check(mode, rows[r][3:0], "device modes");
      check(portOutMode, rows[r][3:0], "host mirror");
      $display("row %0d done", r);
    end
    run(8'h5E, 1'b1);
    check(pins[7:4], 4'hE, "refused request");
    $display("busy refusal done");
    @(posedge mclk);
    #2;
    reqValid = 1'b1;
    reqCmd = 8'h6F;
    @(posedge mclk);
    #2;
    reqValid = 1'b0;
    @(posedge mclk);
    #2;
    rst_n = 1'b0;
    #1;
    check({csN, strobe, nibOe, busy, portOutMode}, 8'hC0, "mid reset");
    @(posedge mclk);
    #2;
    rst_n = 1'b1;
    check(mode, 4'h2, "abort left ports");
    run(8'h20, 1'b0);
    check(rdData, 4'hA, "read after abort");
    check(tErr, 0, "pin timing");
    $display("reset abort done");
    report_and_stop();
  end
endmodule : nie_host_tb
